// [mic_interrupt_controller.sv]
/*
 * Interrupt controller of an 8-bit core: request flags, enables,
 * global enable, shadow save/restore and vectoring, on APB.
 * Assumes event pulses and CPU strobes come from logic on clk.
 */
// Notes on behaviour
// RULE1: A source event sets its flag whatever its enable bit says.
// RULE2: A disabled source never sends the program counter to a vector.
// RULE3: Enabled and flagged source loads its vector into the PC.
// RULE4: Accumulator and registers 0x80-0x8F are saved before the vector load.
// RULE5: Entry leaves the RAM bank selection as it was.
// RULE6: Return reloads accumulator and 0x80-0x8F, bank included.
// RULE7: Saved set covers L,H,R,Z,Y,X, flags, bank and W0-W7.
// RULE8: Entry pushes one stack level and vectors within 8 to 14.
// RULE9: Service ends only on return, popping the pushed level.
// RULE10: First enable register holds pin0, pin1, T0, TC0, TC1, TC2.
// RULE11: Second enable register holds wakeup, serial, UART rx/tx, MSP.
// RULE12: Hardware sets flags; software alone clears them by writing.
// RULE13: First flag register holds pin0, pin1, T0, TC0, TC1, TC2.
// RULE14: Second flag register holds wakeup, serial, UART rx/tx, MSP.
// RULE15: No service while global enable bit 7 is zero; resets zero.
// RULE16: Entry clears global enable; return sets it again.
// RULE17: Pin0 vectors to 0x0009, pin1 to 0x000A.
// RULE18: Several pending: lowest vector address wins.
// RULE19: Requests are taken only at instruction boundaries.
`default_nettype none

module mic_interrupt_controller (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [9:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output var  logic [31:0]  prdata,
  output var  logic         pready,
  output var  logic         pslverr,
  input  wire logic [10:0]  src_event,
  input  wire logic         low_voltage_flag_a,
  input  wire logic         low_voltage_flag_b,
  input  wire logic         instr_boundary,
  input  wire logic         return_from_interrupt_instr,
  input  wire logic [7:0]   accumulator,
  input  wire logic [127:0] work_regs,
  output var  logic         pc_load,
  output var  logic [15:0]  pc_vector,
  output var  logic         stack_push,
  output var  logic         stack_pop,
  output logic              cpu_restore,
  output logic [7:0]        acc_restore,
  output logic [127:0]      wreg_restore,
  output var  logic         irq
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic is_reg(input logic [9:0] a,
                                  input logic [7:0] idx);
    return a == {idx, 2'b00};
  endfunction

  // Wakeup and the four serial-type sources share the lowest vector;
  // only seven vector slots exist for eleven sources.
  function automatic logic [15:0] pick_vec(input logic [10:0] p);
    if (|p[10:mic_pkg::LO_BITS]) begin
      return mic_pkg::VEC_WAKE;
    end else if (p[mic_pkg::SRC_EXT0]) begin
      return mic_pkg::VEC_EXT0;
    end else if (p[mic_pkg::SRC_EXT1]) begin
      return mic_pkg::VEC_EXT1;
    end else if (p[mic_pkg::SRC_T0]) begin
      return mic_pkg::VEC_T0;
    end else if (p[mic_pkg::SRC_TC0]) begin
      return mic_pkg::VEC_TC0;
    end else if (p[mic_pkg::SRC_TC1]) begin
      return mic_pkg::VEC_TC1;
    end else begin
      return mic_pkg::VEC_TC2;
    end
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  mic_pkg::mic_state_t state_q;
  logic [10:0]  flags_q;
  logic [10:0]  en_q;
  logic         gie_q;
  logic [2:0]   stk_q;
  logic [1:0]   ev_status_q;
  logic [1:0]   ev_mask_q;
  logic [15:0]  vec_q;
  logic [10:0]  next_flags;
  logic [1:0]   next_ev_status;
  logic [10:0]  pending;
  logic         take;
  logic         acc_ph;
  logic         wr_fire;
  logic         hit;
  logic [7:0]   rd_byte;
  logic [1:0]   lvd_meta;
  logic [1:0]   lvd_sync;

  // Detector levels are asynchronous, so two flops before any read
  always_ff @(posedge clk) begin
    lvd_meta <= {low_voltage_flag_a, low_voltage_flag_b};
    lvd_sync <= lvd_meta;
  end

  mic_shadow_if sh ();

  mic_shadow u_shadow (
    .clk (clk),
    .rst (rst),
    .sh  (sh.store)
  );

  // ****************************************************************
  // APB slave
  // ****************************************************************
  assign acc_ph  = psel & penable;
  assign wr_fire = acc_ph & pready & pwrite;

  // One wait state: registers settle the answer before pready
  always_ff @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc_ph & ~pready;
      pslverr <= acc_ph & ~pready & ~hit;
      if (acc_ph & ~pready) begin
        prdata <= {24'h00_0000, rd_byte};
      end
    end
  end

  always_comb begin
    hit     = 1'b1;
    rd_byte = 8'h00;
    if (is_reg(paddr, mic_pkg::IDX_FLAGS_LO)) begin
      rd_byte = {2'b00, flags_q[5:0]};                     // [RULE13]
    end else if (is_reg(paddr, mic_pkg::IDX_FLAGS_HI)) begin
      rd_byte = {3'b000, flags_q[10:6]};                   // [RULE14]
    end else if (is_reg(paddr, mic_pkg::IDX_EN_LO)) begin
      rd_byte = {2'b00, en_q[5:0]};                        // [RULE10]
    end else if (is_reg(paddr, mic_pkg::IDX_EN_HI)) begin
      rd_byte = {3'b000, en_q[10:6]};                      // [RULE11]
    end else if (is_reg(paddr, mic_pkg::IDX_STACK)) begin
      rd_byte = {gie_q, lvd_sync, 2'b00, stk_q};
    end else if (is_reg(paddr, mic_pkg::IDX_EV_STATUS)) begin
      rd_byte = {6'h00, ev_status_q};
    end else if (is_reg(paddr, mic_pkg::IDX_EV_MASK)) begin
      rd_byte = {6'h00, ev_mask_q};
    end else begin
      hit = 1'b0;
    end
  end

  // ****************************************************************
  // Request flags and enables
  // ****************************************************************
  // An event in the cycle of a clearing write still sets its flag
  always_comb begin
    next_flags = flags_q;
    if (wr_fire && is_reg(paddr, mic_pkg::IDX_FLAGS_LO)) begin
      next_flags[5:0] = pwdata[5:0];                       // [RULE13]
    end
    if (wr_fire && is_reg(paddr, mic_pkg::IDX_FLAGS_HI)) begin
      next_flags[10:6] = pwdata[4:0];                      // [RULE14]
    end
    next_flags = next_flags | src_event;           // [RULE1] [RULE12]
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_q <= mic_pkg::FLAGS_RESET;
    end else begin
      flags_q <= next_flags;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      en_q <= mic_pkg::EN_RESET;
    end else begin
      if (wr_fire && is_reg(paddr, mic_pkg::IDX_EN_LO)) begin
        en_q[5:0] <= pwdata[5:0];                          // [RULE10]
      end
      if (wr_fire && is_reg(paddr, mic_pkg::IDX_EN_HI)) begin
        en_q[10:6] <= pwdata[4:0];                         // [RULE11]
      end
    end
  end

  // ****************************************************************
  // Request selection
  // ****************************************************************
  assign pending = flags_q & en_q;                         // [RULE2]
  assign take    = (state_q == mic_pkg::MIC_IDLE) & instr_boundary
                 & gie_q & (|pending);          // [RULE15] [RULE19]

  always_ff @(posedge clk) begin
    if (rst) begin
      vec_q <= mic_pkg::VEC_WAKE;
    end else if (take) begin
      vec_q <= pick_vec(pending);              // [RULE17] [RULE18]
    end
  end

  // ****************************************************************
  // Entry and return sequence
  // ****************************************************************
  // The shadow copy is taken on the boundary edge itself, so the
  // core's registers are never sampled after they start to change.
  assign sh.save    = take;                        // [RULE4] [RULE7]
  assign sh.acc_in  = accumulator;
  assign sh.wreg_in = work_regs;                           // [RULE5]
  assign sh.restore = (state_q == mic_pkg::MIC_REST);      // [RULE6]

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= mic_pkg::MIC_IDLE;
    end else begin
      case (state_q)
        mic_pkg::MIC_IDLE: begin
          if (take) begin
            state_q <= mic_pkg::MIC_VECT;
          end
        end
        mic_pkg::MIC_VECT: begin
          state_q <= mic_pkg::MIC_SERV;
        end
        mic_pkg::MIC_SERV: begin
          if (return_from_interrupt_instr) begin
            state_q <= mic_pkg::MIC_REST;                  // [RULE9]
          end
        end
        mic_pkg::MIC_REST: begin
          state_q <= mic_pkg::MIC_IDLE;
        end
        default: begin
          state_q <= mic_pkg::MIC_IDLE;
        end
      endcase
    end
  end

  // Vector load comes a cycle after the save has completed
  always_ff @(posedge clk) begin
    if (rst) begin
      pc_load    <= 1'b0;
      pc_vector  <= mic_pkg::VEC_WAKE;
      stack_push <= 1'b0;
      stack_pop  <= 1'b0;
    end else begin
      pc_load    <= (state_q == mic_pkg::MIC_VECT);        // [RULE3]
      stack_push <= (state_q == mic_pkg::MIC_VECT);        // [RULE8]
      stack_pop  <= (state_q == mic_pkg::MIC_REST);        // [RULE9]
      if (state_q == mic_pkg::MIC_VECT) begin
        pc_vector <= vec_q;                                // [RULE8]
      end
    end
  end

  // Hardware updates of the stack register win over a software write
  always_ff @(posedge clk) begin
    if (rst) begin
      gie_q <= mic_pkg::GIE_RESET;                        // [RULE15]
    end else if (take) begin
      gie_q <= 1'b0;                                      // [RULE16]
    end else if (state_q == mic_pkg::MIC_REST) begin
      gie_q <= 1'b1;                                      // [RULE16]
    end else if (wr_fire && is_reg(paddr, mic_pkg::IDX_STACK)) begin
      gie_q <= pwdata[mic_pkg::GIE_BIT];                  // [RULE15]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stk_q <= mic_pkg::STK_RESET;
    end else if (state_q == mic_pkg::MIC_VECT) begin
      stk_q <= stk_q - 3'h1;                               // [RULE8]
    end else if (state_q == mic_pkg::MIC_REST) begin
      stk_q <= stk_q + 3'h1;                               // [RULE9]
    end else if (wr_fire && is_reg(paddr, mic_pkg::IDX_STACK)) begin
      stk_q <= pwdata[2:0];
    end
  end

  assign cpu_restore  = sh.restored;                       // [RULE6]
  assign acc_restore  = sh.acc_out;
  assign wreg_restore = sh.wreg_out;

  // ****************************************************************
  // Event status, mask and interrupt line
  // ****************************************************************
  always_comb begin
    next_ev_status = ev_status_q;
    if (wr_fire && is_reg(paddr, mic_pkg::IDX_EV_STATUS)) begin
      next_ev_status = ev_status_q & ~pwdata[1:0];
    end
    next_ev_status[mic_pkg::EV_ENTRY] = next_ev_status[mic_pkg::EV_ENTRY]
                                      | (state_q == mic_pkg::MIC_VECT);
    next_ev_status[mic_pkg::EV_EXIT]  = next_ev_status[mic_pkg::EV_EXIT]
                                      | (state_q == mic_pkg::MIC_REST);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ev_status_q <= 2'h0;
      ev_mask_q   <= 2'h0;
      irq         <= 1'b0;
    end else begin
      ev_status_q <= next_ev_status;
      if (wr_fire && is_reg(paddr, mic_pkg::IDX_EV_MASK)) begin
        ev_mask_q <= pwdata[1:0];
      end
      irq <= |(ev_status_q & ev_mask_q);
    end
  end

endmodule

`default_nettype wire

// [mic_pkg.sv]
/*
 * Constants, register map and state codes of the interrupt controller.
 * Assumes a 32-bit APB master and byte addresses of four times the index.
 */
`default_nettype none

package mic_pkg;

  // ****************************************************************
  // Register indices; byte address is four times the index
  // ****************************************************************
  localparam logic [7:0]  IDX_FLAGS_LO  = 8'h97;
  localparam logic [7:0]  IDX_FLAGS_HI  = 8'h98;
  localparam logic [7:0]  IDX_EN_LO     = 8'h9A;
  localparam logic [7:0]  IDX_EN_HI     = 8'h9B;
  localparam logic [7:0]  IDX_STACK     = 8'hEF;
  localparam logic [7:0]  IDX_EV_STATUS = 8'hF0;
  localparam logic [7:0]  IDX_EV_MASK   = 8'hF1;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int          NUM_SRC       = 11;
  localparam int          LO_BITS       = 6;
  localparam int          HI_BITS       = 5;
  localparam int          GIE_BIT       = 7;
  localparam int          STK_BITS      = 3;
  localparam int          NUM_EV        = 2;
  localparam int          EV_ENTRY      = 0;
  localparam int          EV_EXIT       = 1;
  localparam int          SHADOW_BYTES  = 17;
  localparam int          WREG_BITS     = 128;

  // Source index inside the combined flag vector
  localparam int          SRC_EXT0      = 0;
  localparam int          SRC_EXT1      = 1;
  localparam int          SRC_T0        = 2;
  localparam int          SRC_TC0       = 3;
  localparam int          SRC_TC1       = 4;
  localparam int          SRC_TC2       = 5;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [10:0] FLAGS_RESET   = 11'h000;
  localparam logic [10:0] EN_RESET      = 11'h000;
  localparam logic [2:0]  STK_RESET     = 3'h7;
  localparam logic        GIE_RESET     = 1'b0;

  // ****************************************************************
  // Vector addresses
  // ****************************************************************
  localparam logic [15:0] VEC_WAKE      = 16'h0008;
  localparam logic [15:0] VEC_EXT0      = 16'h0009;
  localparam logic [15:0] VEC_EXT1      = 16'h000A;
  localparam logic [15:0] VEC_T0        = 16'h000B;
  localparam logic [15:0] VEC_TC0       = 16'h000C;
  localparam logic [15:0] VEC_TC1       = 16'h000D;
  localparam logic [15:0] VEC_TC2       = 16'h000E;

  typedef enum logic [3:0] {
    MIC_IDLE = 4'h1,
    MIC_VECT = 4'h2,
    MIC_SERV = 4'h4,
    MIC_REST = 4'h8
  } mic_state_t;

endpackage

`default_nettype wire

// [mic_shadow_if.sv]
/*
 * Carrier between the controller and its shadow buffer.
 * Assumes both ends run on the same clock.
 */
`default_nettype none

interface mic_shadow_if;
  logic         save;
  logic         restore;
  logic [7:0]   acc_in;
  logic [127:0] wreg_in;
  logic [7:0]   acc_out;
  logic [127:0] wreg_out;
  logic         restored;

  modport ctrl  (output save, output restore, output acc_in,
                 output wreg_in, input acc_out, input wreg_out,
                 input restored);
  modport store (input save, input restore, input acc_in,
                 input wreg_in, output acc_out, output wreg_out,
                 output restored);
endinterface

`default_nettype wire

// [mic_shadow.sv]
/*
 * Shadow buffer for the accumulator and sixteen working registers.
 * Assumes save and restore are never high in the same cycle.
 */
`default_nettype none

module mic_shadow (
  input  wire logic clk,
  input  wire logic rst,
  mic_shadow_if.store sh
);

  logic [7:0] buf_q [mic_pkg::SHADOW_BYTES];

  // ****************************************************************
  // Storage
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < mic_pkg::SHADOW_BYTES; i++) begin
        buf_q[i] <= 8'h00;
      end
    end else if (sh.save) begin
      buf_q[0] <= sh.acc_in;
      for (int i = 1; i < mic_pkg::SHADOW_BYTES; i++) begin
        buf_q[i] <= sh.wreg_in[(i-1)*8 +: 8];
      end
    end
  end

  // ****************************************************************
  // Reload
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      sh.acc_out  <= 8'h00;
      sh.wreg_out <= '0;
      sh.restored <= 1'b0;
    end else begin
      sh.restored <= sh.restore;
      if (sh.restore) begin
        sh.acc_out <= buf_q[0];
        for (int i = 1; i < mic_pkg::SHADOW_BYTES; i++) begin
          sh.wreg_out[(i-1)*8 +: 8] <= buf_q[i];
        end
      end
    end
  end

endmodule

`default_nettype wire

// [mic_interrupt_controller_monitor.sv]
/*
 * Port checker for the interrupt controller.
 * Assumes it is bound to the top module and sees only its ports.
 */
`default_nettype none

module mic_interrupt_controller_monitor (
  input wire logic         clk,
  input wire logic         rst,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire logic         instr_boundary,
  input wire logic         return_from_interrupt_instr,
  input wire logic [7:0]   accumulator,
  input wire logic [127:0] work_regs,
  input wire logic         pc_load,
  input wire logic [15:0]  pc_vector,
  input wire logic         stack_push,
  input wire logic         stack_pop,
  input wire logic         cpu_restore,
  input wire logic [7:0]   acc_restore,
  input wire logic [127:0] wreg_restore,
  input wire logic         irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // Helper state
  // ************************************************************
  logic         in_serv;
  logic [7:0]   sv_acc;
  logic [127:0] sv_wreg;
  logic [1:0]   hist;
  always_ff @(posedge clk) begin
    if (rst) in_serv <= 1'b0;
    else if (pc_load) in_serv <= 1'b1;
    else if (cpu_restore) in_serv <= 1'b0;
  end
  // Captured two edges back: the take edge precedes pc_load by two
  always_ff @(posedge clk) begin
    if (pc_load) begin
      sv_acc <= $past(accumulator, 2);
      sv_wreg <= $past(work_regs, 2);
    end
  end
  always_ff @(posedge clk) begin
    if (rst) hist <= 2'b00;
    else hist <= {hist[0], pc_load | cpu_restore | pready};
  end
  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_push_with_load: assert property (pc_load |-> stack_push)
    else $error("push missing at vector load");
  a_vector_range: assert property (pc_load |->
    pc_vector >= 16'h0008 && pc_vector <= 16'h000E)
    else $error("vector outside 8 to 14");
  a_take_boundary: assert property ($rose(pc_load) |->
    $past(instr_boundary, 2)) else $error("take off boundary");
  a_no_reenter: assert property (pc_load |-> !in_serv)
    else $error("vector load while servicing");
  a_return_pop: assert property (in_serv &&
    return_from_interrupt_instr |-> ##2 stack_pop && cpu_restore)
    else $error("return not followed by pop");
  a_pop_in_serv: assert property (stack_pop |-> in_serv)
    else $error("pop outside service");
  a_restore_data: assert property (cpu_restore |->
    acc_restore == sv_acc && wreg_restore == sv_wreg)
    else $error("restored values differ from saved");
  a_irq_cause: assert property ($rose(irq) |-> hist != 2'b00)
    else $error("irq rose without cause");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_err_zero: assert property (pslverr |->
    pready && prdata == 32'h0000_0000) else $error("bad error reply");
  c_entry: cover property (pc_load);
  c_exit: cover property (cpu_restore);
  c_err: cover property (pslverr);
endmodule

bind mic_interrupt_controller mic_interrupt_controller_monitor
  mic_interrupt_controller_monitor_inst (.*);

`default_nettype wire

// [mic_core_model.sv]
/*
 * Behavioural core: instruction boundaries, live registers, return.
 * Assumes it shares clk and rst with the controller.
 */
`default_nettype none

module mic_core_model #(
  parameter int RET_DELAY = 40
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         pc_load,
  output var  logic         instr_boundary,
  output var  logic         return_from_interrupt_instr,
  output var  logic [7:0]   accumulator,
  output var  logic [127:0] work_regs
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cyc;
  int         cnt;
  // Values change every cycle so a late or early capture shows
  always_ff @(posedge clk) begin
    if (rst) cyc <= 8'h00;
    else cyc <= cyc + 8'h01;
  end
  assign instr_boundary = cyc[0];
  assign accumulator = cyc ^ 8'h5A;
  assign work_regs = {16{cyc + 8'h11}};
  // Return only some cycles after the vector load
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 0;
      return_from_interrupt_instr <= 1'b0;
    end else begin
      return_from_interrupt_instr <= (cnt == 1);
      if (pc_load) cnt <= RET_DELAY;
      else if (cnt != 0) cnt <= cnt - 1;
    end
  end
endmodule

`default_nettype wire

// [mic_interrupt_controller_tb.sv]
/*
 * Self-checking bench of the interrupt controller over APB.
 * Assumes the core model answers every vector load with a return.
 */
`default_nettype none

module mic_interrupt_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pslverr, pready, pc_load, stack_push, stack_pop;
  logic ib, ret, cpu_restore, irq, e;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic [10:0] src_event = 11'h000;
  logic [7:0] acc, acc_restore;
  logic [127:0] wreg, wreg_restore;
  logic [15:0] pc_vector, last_vec;
  int n_fail = 0, samples_checked = 0, n_load = 0, n_pop = 0, l0;
  typedef struct {logic [7:0] idx, wd, ex;} mic_row_t;
  mic_row_t rows [12] = '{
    '{mic_pkg::IDX_FLAGS_LO, 8'hFF, 8'h3F}, '{mic_pkg::IDX_FLAGS_HI, 8'hFF, 8'h1F},
    '{mic_pkg::IDX_FLAGS_LO, 8'h00, 8'h00}, '{mic_pkg::IDX_FLAGS_HI, 8'h00, 8'h00},
    '{mic_pkg::IDX_EN_LO, 8'hFF, 8'h3F}, '{mic_pkg::IDX_EN_HI, 8'hFF, 8'h1F},
    '{mic_pkg::IDX_EN_LO, 8'h00, 8'h00}, '{mic_pkg::IDX_EN_HI, 8'h00, 8'h00},
    '{mic_pkg::IDX_EV_MASK, 8'hFF, 8'h03}, '{mic_pkg::IDX_EV_MASK, 8'h00, 8'h00},
    '{mic_pkg::IDX_STACK, 8'h05, 8'h45}, '{mic_pkg::IDX_STACK, 8'h07, 8'h47}};

  always #5 clk = ~clk;

  mic_interrupt_controller mic_interrupt_controller_inst (.clk(clk),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_event(src_event), .low_voltage_flag_a(1'b1),
    .low_voltage_flag_b(1'b0), .instr_boundary(ib),
    .return_from_interrupt_instr(ret), .accumulator(acc),
    .work_regs(wreg), .pc_load(pc_load), .pc_vector(pc_vector),
    .stack_push(stack_push), .stack_pop(stack_pop),
    .cpu_restore(cpu_restore), .acc_restore(acc_restore),
    .wreg_restore(wreg_restore), .irq(irq));
  mic_core_model mic_core_model_inst (.clk(clk), .rst(rst),
    .pc_load(pc_load), .instr_boundary(ib),
    .return_from_interrupt_instr(ret), .accumulator(acc), .work_regs(wreg));

  always @(posedge clk) begin
    if (pc_load === 1'b1) begin
      n_load++;
      last_vec = pc_vector;
    end
    if (stack_pop === 1'b1) n_pop++;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, ex);
    samples_checked++;
    if (seen !== ex) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, ex, seen);
    end
  endtask
  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_fail++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h0000_00, d});
  endtask
  task automatic rd_chk(input string what, input logic [7:0] idx, ex);
    apb(1'b0, idx, 32'h0000_0000);
    check(what, r, {24'h0000_00, ex});
  endtask
  task automatic fire(input logic [10:0] ev);
    @(posedge clk);
    src_event <= ev;
    @(posedge clk);
    src_event <= 11'h000;
  endtask
  // Waits for entry, clears flags in the routine, waits for exit
  task automatic serve(input logic [15:0] vec, input logic [7:0] keep,
                       input logic after);
    int p0, n;
    l0 = n_load;
    p0 = n_pop;
    n = 0;
    while (n_load == l0 && n < 300) begin @(posedge clk); n++; end
    check("entries", n_load - l0, 1);
    check("vector", {16'h0000, last_vec}, {16'h0000, vec});
    wr(mic_pkg::IDX_FLAGS_LO, keep);
    wr(mic_pkg::IDX_FLAGS_HI, 8'h00);
    rd_chk("stack in service", mic_pkg::IDX_STACK, 8'h46);
    while (n_pop == p0 && n < 300) begin @(posedge clk); n++; end
    check("pops", n_pop - p0, 1);
    if (after) rd_chk("stack after", mic_pkg::IDX_STACK, 8'hC7);
  endtask

  initial begin
    #100us;
    n_fail++;
    finish_test();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd);
      rd_chk("register", rows[i].idx, rows[i].ex);
    end
    $display("register rows done");
    // Mid-run reset must bring back the reset values
    wr(mic_pkg::IDX_EN_LO, 8'h3F);
    wr(mic_pkg::IDX_STACK, 8'h87);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk("enable reset", mic_pkg::IDX_EN_LO, 8'h00);
    rd_chk("stack reset", mic_pkg::IDX_STACK, 8'h47);
    apb(1'b0, 8'h10, 32'h0000_0000);
    check("unmapped err", {31'h0, e}, 32'h0000_0001);
    check("unmapped data", r, 32'h0000_0000);
    $display("reset and unmapped done");
    wr(mic_pkg::IDX_STACK, 8'h87);
    fire(11'h001);
    l0 = n_load;
    repeat (20) @(posedge clk);
    check("disabled entry", n_load - l0, 0);
    rd_chk("flag set", mic_pkg::IDX_FLAGS_LO, 8'h01);
    wr(mic_pkg::IDX_STACK, 8'h07);
    wr(mic_pkg::IDX_EN_LO, 8'h01);
    repeat (20) @(posedge clk);
    check("global off entry", n_load - l0, 0);
    rd_chk("flag kept", mic_pkg::IDX_FLAGS_LO, 8'h01);
    wr(mic_pkg::IDX_STACK, 8'h87);
    serve(16'h0009, 8'h00, 1'b1);
    $display("enable gating done");
    for (int i = 0; i < 11; i++) begin
      wr(mic_pkg::IDX_EN_LO, i < 6 ? 8'h01 << i : 8'h00);
      wr(mic_pkg::IDX_EN_HI, i >= 6 ? 8'h01 << (i - 6) : 8'h00);
      fire(11'h001 << i);
      serve(i < 6 ? 16'h0009 + i : 16'h0008, 8'h00, 1'b1);
    end
    $display("all sources done");
    wr(mic_pkg::IDX_STACK, 8'h07);
    wr(mic_pkg::IDX_EV_MASK, 8'h01);
    wr(mic_pkg::IDX_EN_LO, 8'h3F);
    wr(mic_pkg::IDX_EN_HI, 8'h1F);
    fire(11'h422);
    wr(mic_pkg::IDX_STACK, 8'h87);
    serve(16'h0008, 8'h22, 1'b0);
    serve(16'h000A, 8'h20, 1'b0);
    serve(16'h000E, 8'h00, 1'b1);
    check("irq raised", {31'h0, irq}, 32'h0000_0001);
    rd_chk("event status", mic_pkg::IDX_EV_STATUS, 8'h03);
    wr(mic_pkg::IDX_EV_MASK, 8'h00);
    repeat (3) @(posedge clk);
    check("irq masked", {31'h0, irq}, 32'h0000_0000);
    wr(mic_pkg::IDX_EV_MASK, 8'h01);
    repeat (3) @(posedge clk);
    check("irq unmasked", {31'h0, irq}, 32'h0000_0001);
    wr(mic_pkg::IDX_EV_STATUS, 8'h03);
    repeat (3) @(posedge clk);
    check("irq cleared", {31'h0, irq}, 32'h0000_0000);
    rd_chk("status cleared", mic_pkg::IDX_EV_STATUS, 8'h00);
    $display("priority and irq done");
    finish_test();
  end
endmodule

`default_nettype wire
